// *** vpi_pkg.sv ***
// Shared constants and carriers of the video pixel input port.
// Assumes 32-bit AXI4-Lite data, word-aligned registers, 8-bit pixel bus.
`default_nettype none
package vpi_pkg;
    localparam int unsigned VPI_ADDR_W = 8;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] VPI_IDX_CONFIG = 6'h01;
    localparam logic [5:0] VPI_IDX_CTRL = 6'h02;
    localparam logic [5:0] VPI_IDX_STATUS = 6'h03;
    localparam logic [5:0] VPI_IDX_SAMPLE = 6'h04;
    localparam logic [5:0] VPI_IDX_EAVCNT = 6'h05;

    // Config register layout: mode in [6:4], luma edge in [2:1]
    localparam int unsigned VPI_MODE_LSB = 4;
    localparam int unsigned VPI_EDGE_LSB = 1;
    localparam logic [7:0] VPI_CONFIG_MASK = 8'h76;
    localparam logic [7:0] VPI_CONFIG_RST = 8'h00;

    // Control register layout
    localparam int unsigned VPI_CTRL_CAP = 0;
    localparam int unsigned VPI_CTRL_EXT = 1;
    localparam logic [1:0] VPI_CTRL_RST = 2'h1;

    // Input mode codes
    localparam logic [2:0] VPI_MODE_SD = 3'h0;
    localparam logic [2:0] VPI_MODE_DDR = 3'h2;
    localparam logic [2:0] VPI_MODE_ED54 = 3'h7;
    localparam logic [1:0] VPI_EDGE_LUMA_FALL = 2'h3;

    // Timing reference preamble bytes
    localparam logic [7:0] VPI_TRS_ONES = 8'hFF;
    localparam logic [7:0] VPI_TRS_ZEROS = 8'h00;

    // Bus answers
    localparam logic [1:0] VPI_RESP_OKAY = 2'h0;
    localparam logic [1:0] VPI_RESP_SLVERR = 2'h2;

    localparam int unsigned VPI_CNT_W = 16;

    // Settings carried into the pixel clock domain
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] luma_edge;
        logic capture_en;
        logic ext_sync_en;
    } vpi_cfg_t;

    // Decoded timing reference state
    typedef struct packed {
        logic hit;
        logic busy;
        logic f;
        logic v;
        logic h;
    } vpi_code_t;

    // One captured 4:2:2 sample with its timing
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic valid;
        logic field;
        logic vblank;
        logic hblank;
    } vpi_video_t;
endpackage
`default_nettype wire

// *** vpi_sync.sv ***
// Two-flop synchroniser for levels and gray-coded words.
// Assumes each bit may change at most once per destination sample.
`timescale 1ns/1ps
`default_nettype none
module vpi_sync
    import vpi_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    clk,
    d,
    q
);
    input wire logic clk;
    input wire logic [WIDTH-1:0] d;
    output logic [WIDTH-1:0] q;

    logic [1:0][WIDTH-1:0] st;
    logic [1:0][WIDTH-1:0] next_st;

    // First stage feeds only the second; no reset so it may sync a reset
    always_comb begin
        next_st[0] = d;
        next_st[1] = st[0];
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st[1];
endmodule
`default_nettype wire

// *** vpi_trs_dec.sv ***
// Embedded timing reference decoder (FF 00 00 XY) on the pixel clock.
// Assumes one or two bytes per cycle, oldest in b0; output is one cycle late.
`timescale 1ns/1ps
`default_nettype none
module vpi_trs_dec
    import vpi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    input wire logic two,
    output vpi_code_t code
);
    typedef struct packed {
        logic [1:0] cnt;
        vpi_code_t code;
    } vpi_dec_t;

    vpi_dec_t st;
    vpi_dec_t next_st;

    // Preamble walk for one byte: {hit, next count}
    function automatic logic [2:0] trs_step(input logic [1:0] cnt, input logic [7:0] b);
        logic [2:0] r;
        r = 3'h0;
        case (cnt)
            2'h0: r = (b == VPI_TRS_ONES) ? 3'h1 : 3'h0;
            2'h1, 2'h2: r = (b == VPI_TRS_ZEROS) ? {1'b0, cnt + 2'h1} : 3'h0;
            default: r = {b[7], 2'h0}; // Marker bit must be set
        endcase
        return r;
    endfunction

    // Walk both bytes in arrival order, keep flags of the last code
    always_comb begin
        logic [2:0] s0;
        logic [2:0] s1;
        logic [7:0] xy;
        s0 = 3'h0;
        s1 = 3'h0;
        xy = b0;
        next_st = st;
        next_st.code.hit = 1'b0;
        next_st.code.busy = 1'b0;
        if (in_valid) begin
            s0 = trs_step(st.cnt, b0);
            next_st.cnt = s0[1:0];
            next_st.code.busy = |s0;
            next_st.code.hit = s0[2];
            if (two) begin
                s1 = trs_step(s0[1:0], b1);
                next_st.cnt = s1[1:0];
                next_st.code.busy = (|s0) | (|s1);
                next_st.code.hit = s0[2] | s1[2];
                if (s1[2]) begin
                    xy = b1;
                end
            end
            if (next_st.code.hit) begin
                next_st.code.f = xy[6];
                next_st.code.v = xy[5];
                next_st.code.h = xy[4];
            end
        end
    end

    // Starts in blanking until the first start code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '{cnt: 2'h0, code: '{hit: 1'b0, busy: 1'b0, f: 1'b0, v: 1'b1, h: 1'b1}};
        end else begin
            st <= next_st;
        end
    end

    assign code = st.code;
endmodule
`default_nettype wire

// *** vpi_top.sv ***
// Video pixel input port: AXI4-Lite registers plus 8-bit 4:2:2 capture.
// Assumes the source drives pixel_bus, hsync_n and vsync_n from pixel_clock_input.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The input mode comes from config bits 6 to 4, written by software.
// - After reset the mode field holds 000, standard definition.
// - Mode 000 takes interleaved 4:2:2 bytes on the 8-bit bus, one per clock.
// - In modes 000 and 010 separate syncs may be supplied and are then used.
// - In modes 000 and 010 timing is also taken from embedded EAV and SAV codes.
// - Mode 000 follows the BT.601/656 byte order and timing code layout.
// - Bus bit 0 is the least significant bit of each byte.
// - Mode 010 takes 4:2:2 bytes on a double-data-rate 8-bit bus.
// - In mode 010 luma comes on one edge and chroma on the other.
// - Config bits 2 to 1 pick whether luma is taken on rising or falling edges.
// - A standard-definition-only build accepts mode 000 alone.
// - Mode 111 takes 4:2:2 bytes on the 8-bit bus at 54 MHz.
// - In mode 111 only embedded codes carry timing; syncs are ignored.
module vpi_top
    import vpi_pkg::*;
#(
    parameter bit SD_ONLY = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [VPI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [VPI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pixel_clock_input,
    input wire logic [7:0] pixel_bus,
    input wire logic hsync_n,
    input wire logic vsync_n,
    output vpi_video_t video
);
    // Bus-side state
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [VPI_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic [7:0] config_reg;
        logic [1:0] ctrl;
        logic ack;
        logic [15:0] sample;
    } vpi_bus_t;

    // One pipeline stage of captured bytes
    typedef struct packed {
        logic valid;
        logic [7:0] b0;
        logic [7:0] b1;
        logic two;
        logic hs;
        logic vs;
    } vpi_stage_t;

    // Pixel-side state
    typedef struct packed {
        vpi_stage_t s1;
        vpi_stage_t s2;
        logic phase;
        logic [7:0] c_hold;
        vpi_video_t video;
        logic seen;
        logic req;
        logic [15:0] word;
        logic [VPI_CNT_W-1:0] eav_cnt;
        logic [VPI_CNT_W-1:0] eav_gray;
    } vpi_link_t;

    vpi_bus_t bus;
    vpi_bus_t next_bus;
    vpi_link_t lk;
    vpi_link_t next_lk;
    vpi_cfg_t cfg_a;
    vpi_cfg_t cfg_l;
    vpi_code_t code;
    logic link_rst_n;
    logic ack_l;
    logic [7:0] neg_byte;
    logic [VPI_CNT_W+4:0] to_bus;
    logic [VPI_CNT_W+4:0] at_bus;

    function automatic logic mode_supported(input logic [2:0] m, input logic sd_only);
        logic ok;
        ok = (m == VPI_MODE_SD);
        if (!sd_only) begin
            ok = ok || (m == VPI_MODE_DDR) || (m == VPI_MODE_ED54);
        end
        return ok;
    endfunction

    function automatic logic [5:0] reg_index(input logic [VPI_ADDR_W-1:0] a);
        return a[VPI_ADDR_W-1:2];
    endfunction

    function automatic logic [VPI_CNT_W-1:0] bin2gray(input logic [VPI_CNT_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [VPI_CNT_W-1:0] gray2bin(input logic [VPI_CNT_W-1:0] g);
        logic [VPI_CNT_W-1:0] b;
        b = g;
        for (int i = VPI_CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Settings as seen by the pixel side
    always_comb begin
        cfg_a.mode = bus.config_reg[VPI_MODE_LSB +: 3];
        cfg_a.luma_edge = bus.config_reg[VPI_EDGE_LSB +: 2];
        cfg_a.capture_en = bus.ctrl[VPI_CTRL_CAP];
        cfg_a.ext_sync_en = bus.ctrl[VPI_CTRL_EXT];
    end

    // Reset, settings and ack into the pixel domain
    vpi_sync #(.WIDTH(1)) u_rst_sync (
        .clk(pixel_clock_input),
        .d(aresetn),
        .q(link_rst_n)
    );

    vpi_sync #(.WIDTH(8)) u_cfg_sync (
        .clk(pixel_clock_input),
        .d({cfg_a, bus.ack}),
        .q({cfg_l, ack_l})
    );

    // Pixel status, request toggle and gray count into the bus domain
    assign to_bus = {lk.seen, lk.video.field, lk.video.vblank, lk.video.hblank, lk.req, lk.eav_gray};

    vpi_sync #(.WIDTH(VPI_CNT_W + 5)) u_stat_sync (
        .clk(aclk),
        .d(to_bus),
        .q(at_bus)
    );

    // Register slave, read and write paths independent
    always_comb begin
        logic [5:0] idx;
        logic req_a;
        idx = 6'h00;
        req_a = at_bus[VPI_CNT_W];
        next_bus = bus;
        if (bus.bvalid && bready) begin
            next_bus.bvalid = 1'b0;
        end
        if (awvalid && bus.awready) begin
            next_bus.aw_held = 1'b1;
            next_bus.aw_addr = awaddr;
        end
        if (wvalid && bus.wready) begin
            next_bus.w_held = 1'b1;
            next_bus.w_byte = wdata[7:0];
            next_bus.w_lane0 = wstrb[0];
        end
        // Write once both halves are in; read-only words ignore data
        if (next_bus.aw_held && next_bus.w_held && !bus.bvalid) begin
            idx = reg_index(next_bus.aw_addr);
            next_bus.bresp = VPI_RESP_OKAY;
            case (idx)
                VPI_IDX_CONFIG: begin
                    if (next_bus.w_lane0) begin
                        next_bus.config_reg = next_bus.w_byte & VPI_CONFIG_MASK;
                    end
                end
                VPI_IDX_CTRL: begin
                    if (next_bus.w_lane0) begin
                        next_bus.ctrl = next_bus.w_byte[1:0];
                    end
                end
                VPI_IDX_STATUS, VPI_IDX_SAMPLE, VPI_IDX_EAVCNT: begin
                    next_bus.bresp = VPI_RESP_OKAY;
                end
                default: begin
                    next_bus.bresp = VPI_RESP_SLVERR;
                end
            endcase
            next_bus.aw_held = 1'b0;
            next_bus.w_held = 1'b0;
            next_bus.bvalid = 1'b1;
        end
        next_bus.awready = !next_bus.aw_held && !next_bus.bvalid;
        next_bus.wready = !next_bus.w_held && !next_bus.bvalid;

        // Read answers one cycle after the address is taken
        if (bus.rvalid && rready) begin
            next_bus.rvalid = 1'b0;
        end
        if (arvalid && bus.arready) begin
            next_bus.rvalid = 1'b1;
            next_bus.rresp = VPI_RESP_OKAY;
            next_bus.rdata = 32'h0000_0000;
            case (reg_index(araddr))
                VPI_IDX_CONFIG: next_bus.rdata[7:0] = bus.config_reg;
                VPI_IDX_CTRL: next_bus.rdata[1:0] = bus.ctrl;
                VPI_IDX_STATUS: begin
                    next_bus.rdata[0] = at_bus[VPI_CNT_W+3];
                    next_bus.rdata[1] = at_bus[VPI_CNT_W+2];
                    next_bus.rdata[2] = at_bus[VPI_CNT_W+1];
                    next_bus.rdata[3] = !mode_supported(cfg_a.mode, SD_ONLY);
                    next_bus.rdata[4] = at_bus[VPI_CNT_W+4];
                end
                VPI_IDX_SAMPLE: next_bus.rdata[15:0] = bus.sample;
                VPI_IDX_EAVCNT: next_bus.rdata[VPI_CNT_W-1:0] = gray2bin(at_bus[VPI_CNT_W-1:0]);
                default: next_bus.rresp = VPI_RESP_SLVERR;
            endcase
        end
        next_bus.arready = !next_bus.rvalid;

        // Latest sample word: pixel side holds it until this ack returns
        if (req_a != bus.ack) begin
            next_bus.sample = lk.word;
            next_bus.ack = req_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus <= '0;
            bus.awready <= 1'b1;
            bus.wready <= 1'b1;
            bus.arready <= 1'b1;
            bus.config_reg <= VPI_CONFIG_RST;
            bus.ctrl <= VPI_CTRL_RST;
        end else begin
            bus <= next_bus;
        end
    end

    assign awready = bus.awready;
    assign wready = bus.wready;
    assign bvalid = bus.bvalid;
    assign bresp = bus.bresp;
    assign arready = bus.arready;
    assign rvalid = bus.rvalid;
    assign rresp = bus.rresp;
    assign rdata = bus.rdata;

    // Falling-edge half of the double-rate bus
    always_ff @(negedge pixel_clock_input) begin
        neg_byte <= pixel_bus;
    end

    vpi_trs_dec u_trs_dec (
        .clk(pixel_clock_input),
        .rst_n(link_rst_n),
        .in_valid(lk.s1.valid),
        .b0(lk.s1.b0),
        .b1(lk.s1.b1),
        .two(lk.s1.two),
        .code(code)
    );

    // Capture, timing and 4:2:2 pairing on the pixel clock
    always_comb begin
        logic ddr;
        logic ext;
        logic hb;
        logic vb;
        logic emit;
        logic [7:0] y;
        logic [7:0] c;
        ddr = (cfg_l.mode == VPI_MODE_DDR);
        ext = cfg_l.ext_sync_en && (cfg_l.mode != VPI_MODE_ED54);
        emit = 1'b0;
        y = lk.s2.b0;
        c = lk.c_hold;
        next_lk = lk;
        next_lk.video.valid = 1'b0;

        // Stage 1: bus bit 0 stays the byte's LSB in every mode
        next_lk.s1.valid = cfg_l.capture_en && mode_supported(cfg_l.mode, SD_ONLY);
        next_lk.s1.two = ddr;
        next_lk.s1.b0 = ddr ? neg_byte : pixel_bus;
        next_lk.s1.b1 = pixel_bus;
        next_lk.s1.hs = hsync_n;
        next_lk.s1.vs = vsync_n;
        next_lk.s2 = lk.s1;

        // Blanking from syncs when enabled outside mode 111, else from embedded codes
        hb = ext ? !lk.s2.hs : code.h;
        vb = ext ? !lk.s2.vs : code.v;
        next_lk.video.field = code.f;
        next_lk.video.hblank = hb;
        next_lk.video.vblank = vb;

        if (code.hit) begin
            next_lk.phase = 1'b0;
        end else if (lk.s2.valid && !code.busy && !hb && !vb) begin
            if (lk.s2.two) begin
                // Older byte came on the falling edge
                if (cfg_l.luma_edge == VPI_EDGE_LUMA_FALL) begin
                    y = lk.s2.b0;
                    c = lk.s2.b1;
                end else begin
                    y = lk.s2.b1;
                    c = lk.s2.b0;
                end
                emit = 1'b1;
            end else if (!lk.phase) begin
                next_lk.c_hold = lk.s2.b0;
                next_lk.phase = 1'b1;
            end else begin
                y = lk.s2.b0;
                emit = 1'b1;
                next_lk.phase = 1'b0;
            end
        end

        if (emit) begin
            next_lk.video.luma = y;
            next_lk.video.chroma = c;
            next_lk.video.valid = 1'b1;
            next_lk.seen = 1'b1;
            // Refresh the crossing word only once the last one was taken
            if (lk.req == ack_l) begin
                next_lk.word = {y, c};
                next_lk.req = !lk.req;
            end
        end

        // Count end-of-active codes; gray code crosses safely
        if (code.hit && code.h) begin
            next_lk.eav_cnt = lk.eav_cnt + 16'h0001;
        end
        next_lk.eav_gray = bin2gray(next_lk.eav_cnt);
    end

    // Needs the pixel clock running while reset is held
    always_ff @(posedge pixel_clock_input) begin
        if (!link_rst_n) begin
            lk <= '0;
            lk.video.vblank <= 1'b1;
            lk.video.hblank <= 1'b1;
        end else begin
            lk <= next_lk;
        end
    end

    assign video = lk.video;
endmodule
`default_nettype wire

// *** vpi_top_properties.sv ***
// Checker for the pixel input port: bus handshakes and embedded timing codes.
// Assumes it is bound to vpi_top and sees only the ports of that module.
`timescale 1ns/1ps
`default_nettype none
module vpi_top_properties
    import vpi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic pixel_clock_input,
    input wire logic [7:0] pixel_bus,
    input wire vpi_video_t video
);
    // Preamble then status byte; the H bit tells start from end of active video
    sequence trs_seq(logic hbit);
        pixel_bus == VPI_TRS_ONES ##1 pixel_bus == VPI_TRS_ZEROS ##1 pixel_bus == VPI_TRS_ZEROS
            ##1 (pixel_bus[7] && pixel_bus[4] == hbit);
    endsequence

    // Register bus: answer one cycle after taking, held until accepted
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        awvalid && awready && wvalid && wready |=> bvalid) else $error("write not answered");
    a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid |-> !awready && !wready) else $error("write taken while answer pending");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid) else $error("read not answered");
    a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid |-> !arready) else $error("read taken while answer pending");
    a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");

    // Timing codes open and close the active line within a few pixel clocks
    a_sav_opens: assert property (@(posedge pixel_clock_input) disable iff (!aresetn)
        trs_seq(1'b0) |-> ##[1:4] !video.hblank) else $error("line not opened by start code");
    a_eav_closes: assert property (@(posedge pixel_clock_input) disable iff (!aresetn)
        trs_seq(1'b1) |-> ##[1:4] video.hblank) else $error("line not closed by end code");
endmodule

bind vpi_top vpi_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .pixel_clock_input(pixel_clock_input), .pixel_bus(pixel_bus), .video(video));
`default_nettype wire

// *** vpi_src.sv ***
// Behavioural video source: timing codes, 4:2:2 bytes and active-low syncs.
// Assumes the bench supplies the pixel clock and calls line from one process.
`timescale 1ns/1ps
`default_nettype none
module vpi_src
    import vpi_pkg::*;
(
    input wire logic pclk,
    output logic [7:0] pixel_bus,
    output logic hsync_n,
    output logic vsync_n
);
    // Blanking level until the first line
    initial begin
        pixel_bus = 8'h80;
        hsync_n = 1'b0;
        vsync_n = 1'b1;
    end

    // Two bytes: rise then rise, or in DDR fall byte then rise byte
    task automatic put(input bit ddr, input bit hs, input logic [7:0] a, input logic [7:0] b);
        @(posedge pclk);
        pixel_bus <= a;
        hsync_n <= hs;
        if (ddr) begin
            @(negedge pclk);
        end else begin
            @(posedge pclk);
        end
        pixel_bus <= b;
    endtask

    // Start code, payload, end code; the sync follows the codes so both agree
    task automatic line(input bit ddr, input bit vs, input logic [7:0] q[$]);
        int k;
        vsync_n <= vs;
        put(ddr, 1'b1, VPI_TRS_ONES, VPI_TRS_ZEROS);
        put(ddr, 1'b1, VPI_TRS_ZEROS, 8'h80);
        for (k = 0; k < q.size(); k += 2) begin
            put(ddr, 1'b1, q[k], q[k + 1]);
        end
        put(ddr, 1'b0, VPI_TRS_ONES, VPI_TRS_ZEROS);
        put(ddr, 1'b0, VPI_TRS_ZEROS, 8'h90);
        put(ddr, 1'b0, 8'h80, 8'h10);
        vsync_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the pixel input port with a behavioural video source.
// Assumes vpi_top, vpi_src and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top
    import vpi_pkg::*;
;
    logic aclk = '0, aresetn = '0, pclk = '0;
    logic [7:0] awaddr = '0, araddr = '0, pixel_bus;
    logic [31:0] wdata = '0, rdata, dat;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid, hsync_n, vsync_n;
    logic [1:0] bresp, rresp, rsp;
    vpi_video_t video;
    logic [15:0] got[$];
    int err_count = 0, samples_checked = 0, seed = 32'h0000_e60c;

    // Bus clock 50 ns; pixel clock 80 ns with an unrelated phase
    initial forever #25 aclk = ~aclk;
    initial begin
        #7;
        forever #40 pclk = ~pclk;
    end

    vpi_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pixel_clock_input(pclk), .pixel_bus(pixel_bus), .hsync_n(hsync_n),
        .vsync_n(vsync_n), .video(video));
    vpi_src src (.pclk(pclk), .pixel_bus(pixel_bus), .hsync_n(hsync_n), .vsync_n(vsync_n));

    // Collect every sample the port emits
    always @(posedge pclk) if (video.valid === 1'b1) got.push_back({video.luma, video.chroma});

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog so that a hung handshake still reaches the verdict
    initial begin
        repeat (100000) @(posedge aclk);
        err_count++;
        close_out();
    end

    // Payload bytes avoid 00 and FF, which only timing codes may carry
    function automatic logic [7:0] rb();
        return 8'(8'h01 + {$random(seed)} % 254);
    endfunction

    function automatic logic [15:0] exp_pair(input bit ddr, input bit lf, input logic [7:0] b0,
        input logic [7:0] b1);
        return (ddr && lf) ? {b0, b1} : {b1, b0};
    endfunction

    // Bounded wait at falling edges, where registered outputs are settled
    task automatic wt(input int s);
        int n;
        for (n = 0; n < 64; n++) begin
            @(negedge aclk);
            if ((s == 0 ? bvalid : s == 1 ? rvalid : s == 2 ? arready : awready & wready) === 1'b1) break;
        end
        if (n == 64) begin
            err_count++;
            close_out();
        end
    endtask

    // Accept the answer after a random stall, so holding is exercised
    task automatic ans(input bit r);
        @(posedge aclk);
        repeat ({$random(seed)} % 3) @(posedge aclk);
        if (r) rready <= 1'b1; else bready <= 1'b1;
        @(negedge aclk);
        rsp = r ? rresp : bresp;
        dat = rdata;
        @(posedge aclk);
        rready <= '0;
        bready <= '0;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        awaddr <= {i, 2'h0};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wt(3);
        @(posedge aclk);
        awvalid <= '0;
        wvalid <= '0;
        wt(0);
        ans(1'b0);
        `CHK(rsp, VPI_RESP_OKAY)
    endtask

    task automatic rd(input logic [5:0] i);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        wt(2);
        @(posedge aclk);
        arvalid <= '0;
        wt(1);
        ans(1'b1);
    endtask

    task automatic setm(input logic [2:0] m, input logic [1:0] e);
        wr(VPI_IDX_CONFIG, {1'h0, m, 1'h0, e, 1'h0});
    endtask

    // One line of six random pairs, compared against what the bytes imply
    task automatic stream(input bit ddr, input bit lf, input bit vs, input bit on);
        logic [7:0] q[$];
        logic [15:0] e[$];
        logic [7:0] b0, b1;
        int k;
        repeat (10) @(posedge pclk);
        got.delete();
        for (k = 0; k < 6; k++) begin
            b0 = rb();
            b1 = rb();
            q.push_back(b0);
            q.push_back(b1);
            if (on) e.push_back(exp_pair(ddr, lf, b0, b1));
        end
        src.line(ddr, vs, q);
        repeat (8) @(posedge pclk);
        `CHK(got.size(), e.size())
        foreach (e[j]) if (j < got.size()) `CHK(got[j], e[j])
        @(posedge aclk);
    endtask

    initial begin
        int m;
        logic [7:0] v;
        logic [15:0] c;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(VPI_IDX_CONFIG);
        `CHK(dat[7:0], VPI_CONFIG_RST)
        rd(VPI_IDX_CTRL);
        `CHK(dat[1:0], VPI_CTRL_RST)
        rd(6'h3F);
        `CHK(rsp, VPI_RESP_SLVERR)
        for (m = 0; m < 4; m++) begin
            v = rb();
            wr(VPI_IDX_CONFIG, v);
            rd(VPI_IDX_CONFIG);
            `CHK(dat[7:0], v & VPI_CONFIG_MASK)
        end
        // Codes outside the three supported ones stop capture
        for (m = 1; m < 7; m++) begin
            if (m != 2) begin
                setm(3'(m), 2'h0);
                repeat (16) @(posedge aclk);
                rd(VPI_IDX_STATUS);
                `CHK(dat[3], 1'b1)
            end
        end
        stream(1'b1, 1'b0, 1'b1, 1'b0);
        setm(VPI_MODE_SD, 2'h0);
        rd(VPI_IDX_EAVCNT);
        c = dat[15:0];
        stream(1'b0, 1'b0, 1'b1, 1'b1);
        rd(VPI_IDX_EAVCNT);
        `CHK(dat[15:0], c + 16'h0001)
        rd(VPI_IDX_STATUS);
        `CHK(dat[4:0], 5'h14)
        // External syncs: a low vertical sync blanks the line, except at 54 MHz
        wr(VPI_IDX_CTRL, 8'h03);
        stream(1'b0, 1'b0, 1'b0, 1'b0);
        stream(1'b0, 1'b0, 1'b1, 1'b1);
        setm(VPI_MODE_ED54, 2'h0);
        stream(1'b0, 1'b0, 1'b0, 1'b1);
        wr(VPI_IDX_CTRL, 8'h01);
        for (m = 0; m < 4; m++) begin
            setm(VPI_MODE_DDR, 2'(m));
            stream(1'b1, 2'(m) == VPI_EDGE_LUMA_FALL, 1'b1, 1'b1);
        end
        wr(VPI_IDX_CTRL, 8'h00);
        stream(1'b1, 1'b0, 1'b1, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
